// >>> flash_ctrl_map.svh
// Register offsets, field positions, reset values and timing counts of the flash sequencer
`ifndef FLASH_CTRL_MAP_SVH
`define FLASH_CTRL_MAP_SVH

// Register indexes; byte address on the bus is four times the index
`define FCS_INDEX          8'h29
`define PADDR_INDEX        8'h2A
`define PDATA_INDEX        8'h2B
`define OPTSTAT_INDEX      8'h2C
`define MAILBOX_INDEX      8'h2D

// Reset values
`define FCS_RESET          8'h00
`define PADDR_RESET        16'h0000
`define PDATA_RESET        8'h00

// flash_control_status field positions
`define FCS_PROG_BIT       0
`define FCS_SERASE_BIT     1
`define FCS_MERASE_BIT     2
`define FCS_OPTWR_BIT      3
`define FCS_SEC_LSB        4
`define FCS_BUSY_BIT       6
`define FCS_REFUSED_BIT    7

// Option/status register field positions
`define OPT_NEW_RP_BIT     0
`define OPT_CUR_RP_BIT     1
`define OPT_MODE_LSB       2
`define OPT_SIZE_LSB       4
`define OPT_MBOX_FULL_BIT  6

// Sector address map: sectors 0 and 1 are 4 Kbytes at the top
`define SECTOR0_TOP_NIBBLE 4'hF
`define SECTOR1_TOP_NIBBLE 4'hE

// Timing
`define CORE_CLK_PERIOD_NS 100
`define PROG_TIME_NS       20000
`define ERASE_TIME_NS      1000000
`define PROG_CYCLES   ((`PROG_TIME_NS + `CORE_CLK_PERIOD_NS - 1) / `CORE_CLK_PERIOD_NS)
`define ERASE_CYCLES  ((`ERASE_TIME_NS + `CORE_CLK_PERIOD_NS - 1) / `CORE_CLK_PERIOD_NS)

`endif

// >>> flash_ctrl_pkg.sv
// Types shared by the flash sequencer and its serial link receiver
package flash_ctrl_pkg;

  // Sequencer states
  typedef enum logic [1:0]
  {
    SEQ_IDLE  = 2'b00,
    SEQ_RUN   = 2'b01,
    SEQ_CLEAR = 2'b10,
    SEQ_OPT   = 2'b11
  } seq_state_t;

  // Array size codes caught from the straps
  typedef enum logic [1:0]
  {
    SIZE_4K  = 2'b00,
    SIZE_8K  = 2'b01,
    SIZE_BIG = 2'b10
  } size_code_t;

  // Request presented to the flash macro
  typedef struct packed
  {
    logic        prog;
    logic        erase;
    logic        mass;
    logic [1:0]  sector;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } flash_req_t;

endpackage

// >>> flash_seq_checker_sva.sv
// Concurrent checks on the flash sequencer's outputs
`timescale 1ns/1ns
module flash_seq_checker
#(
  parameter int unsigned ERASE_CYCLES = 20
)
(
  input wire logic                  CORE_CLK,
  input wire logic                  RSTN,
  input wire logic                  TOOL_MODE,
  input wire logic                  INCIRCUIT_COMM_MODE,
  input wire logic [1:0]            FLASH_SIZE_STRAP,
  input wire flash_ctrl_pkg::flash_req_t FLASH_REQ,
  input wire logic                  OPTION_READOUT_PROTECT,
  input wire logic                  LOW_VOLTAGE_DETECTOR_EN,
  input wire logic                  EXT_READ_ENABLE
);
  import flash_ctrl_pkg::*;
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RSTN);
  // Any operation on the macro; mass erase excluded from sector checks
  wire act = FLASH_REQ.prog | FLASH_REQ.erase | FLASH_REQ.mass;
  wire sec_op = FLASH_REQ.prog | (FLASH_REQ.erase & ~FLASH_REQ.mass);
  logic mass_seen_r; // Remembers a mass erase since reset
  always_ff @(posedge CORE_CLK)
    if (!RSTN) mass_seen_r <= 1'b0;
    else if (FLASH_REQ.mass) mass_seen_r <= 1'b1;
  lvd_blocked_a: assert property (OPTION_READOUT_PROTECT && $past(OPTION_READOUT_PROTECT)
    |-> !LOW_VOLTAGE_DETECTOR_EN) else $error("detector on while protected");
  ext_blocked_a: assert property ($past(OPTION_READOUT_PROTECT) |-> !EXT_READ_ENABLE)
    else $error("external read open while protected");
  sector0_lock_a: assert property (sec_op && FLASH_REQ.sector == 2'h0
    |-> $past(TOOL_MODE, 3) || $past(INCIRCUIT_COMM_MODE, 3)) else $error("sector 0 touched");
  prog_map_a: assert property (FLASH_REQ.prog |-> FLASH_REQ.sector ==
    (FLASH_REQ.addr[15:12] == 4'hF ? 2'h0 : FLASH_REQ.addr[15:12] == 4'hE ? 2'h1 : 2'h2))
    else $error("program sector does not match address");
  size_map_a: assert property (sec_op && FLASH_REQ.sector != 2'h0 |-> FLASH_SIZE_STRAP != 2'h0
    && (FLASH_REQ.sector == 2'h1 || FLASH_SIZE_STRAP[1])) else $error("absent sector used");
  prog_time_a: assert property ($rose(FLASH_REQ.prog)
    |-> ##199 FLASH_REQ.prog ##1 !FLASH_REQ.prog) else $error("program time wrong");
  idle_zero_a: assert property (!act |-> FLASH_REQ == '0) else $error("idle request not zero");
  mass_first_a: assert property ($fell(OPTION_READOUT_PROTECT) && $past(RSTN, 3)
    |-> mass_seen_r) else $error("protection removed without mass erase");
  cover property ($rose(FLASH_REQ.prog));
  cover property ($rose(FLASH_REQ.erase) && FLASH_REQ.sector == 2'h0);
  cover property ($fell(OPTION_READOUT_PROTECT) && mass_seen_r);
endmodule // flash_seq_checker
bind sector_flash_program_control flash_seq_checker #(.ERASE_CYCLES(ERASE_CYCLES)) chk_inst (
  .CORE_CLK(CORE_CLK), .RSTN(RSTN), .TOOL_MODE(TOOL_MODE), .FLASH_REQ(FLASH_REQ),
  .INCIRCUIT_COMM_MODE(INCIRCUIT_COMM_MODE), .FLASH_SIZE_STRAP(FLASH_SIZE_STRAP),
  .OPTION_READOUT_PROTECT(OPTION_READOUT_PROTECT), .EXT_READ_ENABLE(EXT_READ_ENABLE),
  .LOW_VOLTAGE_DETECTOR_EN(LOW_VOLTAGE_DETECTOR_EN));

// >>> incircuit_link_rx.sv
// Serial byte receiver running on the in-circuit link clock
`timescale 1ns/1ns
module incircuit_link_rx
(
  input  wire logic       link_clk,
  input  wire logic       comm_mode_pin,
  input  wire logic       serial_data_in,
  output logic [7:0]      byte_r,
  output logic            toggle_r
);
  import flash_ctrl_pkg::*;

  logic       mode_s1_r;   // First sync stage of the session pin
  logic       mode_s2_r;   // Session active in the link domain
  logic [7:0] shift_r;     // Bits gathered so far, MSB first
  logic [2:0] count_r;     // Bits gathered in the current byte
  logic       tog_r = 1'b0; // Byte-done toggle; no reset reaches this domain

  //////////////////////////////
  // Session pin synchroniser; data is launched by this clock, so it
  // is sampled directly and a sync stage would only delay the bits
  always_ff @(posedge link_clk)
  begin
    mode_s1_r <= comm_mode_pin;
    mode_s2_r <= mode_s1_r;
  end

  //////////////////////////////
  // Shift in bytes; the byte is held stable until the next byte ends,
  // which leaves eight link clocks for the core to take it over
  always_ff @(posedge link_clk)
  begin
    if (!mode_s2_r)
    begin
      // Outside a session the bit count restarts
      count_r  <= 3'd0;
      shift_r  <= 8'h00;
    end
    else
    begin
      shift_r <= {shift_r[6:0], serial_data_in};
      count_r <= count_r + 3'd1;
      if (count_r == 3'd7)
      begin
        byte_r <= {shift_r[6:0], serial_data_in};
        tog_r  <= ~tog_r;
      end
    end
  end

  assign toggle_r = tog_r;

endmodule // incircuit_link_rx

// >>> link_tool_model.sv
// Behavioural programming tool on the in-circuit link
`timescale 1ns/1ns
module link_tool_model
(
  output logic sclk,
  output logic sdata,
  output logic comm
);
  initial
  begin
    sclk  = 1'b0;
    sdata = 1'b0;
    comm  = 1'b0;
  end
  // One 125 ns link clock; it stands still low between frames
  task pulse();
    #62 sclk = 1'b1;
    #63 sclk = 1'b0;
  endtask
  // Two flush clocks, session entry, two settle clocks, then MSB first
  task send(input logic [7:0] b);
    int i;
    repeat (2) pulse();
    comm = 1'b1;
    repeat (2) pulse();
    for (i = 7; i >= 0; i--)
    begin
      sdata = b[i];
      pulse();
    end
    sdata = ~sdata; // Released line must not keep the last bit
  endtask
endmodule // link_tool_model

// >>> sector_flash_program_control.sv
// Sectored flash program/erase sequencer with AXI4-Lite registers
// Function
// - Erase whole array or one sector; byte program
// - Sector operations leave other sectors untouched
// - Sector count follows array size
// - Sectors 0,1 are 4K; sector 0 at F000h
// - In-application mode never writes sector 0
// - Tool and in-circuit modes reach everything
// - Read-out protection blocks all external extraction
// - Removing protection mass-erases first
// - Low voltage detector off while protected
// - Link is serial clock plus two-way data; data out and its enable are tied low, receive only
// - Control/status register at 0029h, resets 00h
`timescale 1ns/1ns
`include "flash_ctrl_map.svh"
module sector_flash_program_control
#(
  parameter int unsigned ERASE_CYCLES = `ERASE_CYCLES
)
(
  input  wire logic                      CORE_CLK,
  input  wire logic                      RSTN,
  // AXI4-Lite slave
  input  wire logic [7:0]                AWADDR,
  input  wire logic                      AWVALID,
  output logic                           AWREADY,
  input  wire logic [31:0]               WDATA,
  input  wire logic [3:0]                WSTRB,
  input  wire logic                      WVALID,
  output logic                           WREADY,
  output logic [1:0]                     BRESP,
  output logic                           BVALID,
  input  wire logic                      BREADY,
  input  wire logic [7:0]                ARADDR,
  input  wire logic                      ARVALID,
  output logic                           ARREADY,
  output logic [31:0]                    RDATA,
  output logic [1:0]                     RRESP,
  output logic                           RVALID,
  input  wire logic                      RREADY,
  // In-circuit link
  input  wire logic                      INCIRCUIT_SERIAL_CLOCK,
  input  wire logic                      INCIRCUIT_SERIAL_DATA_IN,
  output logic                           INCIRCUIT_SERIAL_DATA_OUT,
  output logic                           INCIRCUIT_SERIAL_DATA_OE,
  input  wire logic                      INCIRCUIT_COMM_MODE,
  // Mode and straps
  input  wire logic                      TOOL_MODE,
  input  wire logic [1:0]                FLASH_SIZE_STRAP,
  input  wire logic                      READOUT_PROTECT_OPTION_BIT,
  input  wire logic                      LOW_VOLTAGE_DETECTOR_REQ,
  // Flash macro and system
  output flash_ctrl_pkg::flash_req_t     FLASH_REQ,
  output logic                           OPTION_READOUT_PROTECT,
  output logic                           LOW_VOLTAGE_DETECTOR_EN,
  output logic                           EXT_READ_ENABLE
);
  import flash_ctrl_pkg::*;

  //////////////////////////////
  // Byte addresses of the registers
  localparam logic [7:0] A_FCS     = 8'({`FCS_INDEX, 2'b00});
  localparam logic [7:0] A_PADDR   = 8'({`PADDR_INDEX, 2'b00});
  localparam logic [7:0] A_PDATA   = 8'({`PDATA_INDEX, 2'b00});
  localparam logic [7:0] A_OPTSTAT = 8'({`OPTSTAT_INDEX, 2'b00});
  localparam logic [7:0] A_MAILBOX = 8'({`MAILBOX_INDEX, 2'b00});
  localparam logic [23:0] PROG_CNT  = 24'(`PROG_CYCLES);
  localparam logic [23:0] ERASE_CNT = 24'(ERASE_CYCLES);
  localparam logic [1:0] RESP_OK    = 2'b00;
  localparam logic [1:0] RESP_SLV   = 2'b10;

  //////////////////////////////
  // Registers
  logic [7:0]  fcs_r;          // Control/status, start bits self-clear
  logic [15:0] paddr_r;        // Byte program address
  logic [7:0]  pdata_r;        // Byte program data
  logic        opt_new_r;      // Protection value for the next option write
  logic        rp_r;           // Current read-out protection
  size_code_t  size_r;         // Array size caught after reset
  logic        strap_done_r;   // Straps taken
  logic [7:0]  mbox_r;         // Last byte from the link
  logic        mbox_full_r;    // Unread byte waiting
  seq_state_t  state_r;        // Sequencer state
  seq_state_t  state_nxt;
  logic [23:0] cnt_r;          // Operation timer
  logic [23:0] cnt_nxt;
  flash_req_t  req_r;          // Request held on the macro
  flash_req_t  req_nxt;
  // Synchronisers for pins
  logic        tool_s1_r, tool_s2_r;
  logic        icc_s1_r, icc_s2_r;
  logic        lvd_s1_r, lvd_s2_r;
  logic        rpo_s1_r, rpo_s2_r;
  logic [1:0]  size_s1_r, size_s2_r;
  logic        tog_s1_r, tog_s2_r, tog_s3_r;
  // Link domain outputs
  logic [7:0]  link_byte;
  logic        link_toggle;
  // Bus slave state
  logic        awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
  logic        aw_got_r, w_got_r;
  logic [7:0]  waddr_r;
  logic [31:0] wdata_r;
  logic [3:0]  wstrb_r;
  logic [1:0]  bresp_r, rresp_r;
  logic [31:0] rdata_r;
  logic        ext_rd_r, lvd_en_r;

  //////////////////////////////
  // Link receiver on its own clock
  incircuit_link_rx u_link
  (
    .link_clk       (INCIRCUIT_SERIAL_CLOCK),
    .comm_mode_pin  (INCIRCUIT_COMM_MODE),
    .serial_data_in (INCIRCUIT_SERIAL_DATA_IN),
    .byte_r         (link_byte),
    .toggle_r       (link_toggle)
  );

  //////////////////////////////
  // Two-flop synchronisers for every pin and the link toggle
  always_ff @(posedge CORE_CLK)
  begin
    tool_s1_r <= TOOL_MODE;
    tool_s2_r <= tool_s1_r;
    icc_s1_r  <= INCIRCUIT_COMM_MODE;
    icc_s2_r  <= icc_s1_r;
    lvd_s1_r  <= LOW_VOLTAGE_DETECTOR_REQ;
    lvd_s2_r  <= lvd_s1_r;
    rpo_s1_r  <= READOUT_PROTECT_OPTION_BIT;
    rpo_s2_r  <= rpo_s1_r;
    size_s1_r <= FLASH_SIZE_STRAP;
    size_s2_r <= size_s1_r;
    tog_s1_r  <= link_toggle;
    tog_s2_r  <= tog_s1_r;
    tog_s3_r  <= tog_s2_r;
  end

  //////////////////////////////
  // Mode and protection decode
  // Tool or in-circuit session gives full access; otherwise the
  // application itself is programming
  wire ext_mode   = tool_s2_r | icc_s2_r;
  wire byte_evt   = tog_s2_r ^ tog_s3_r;
  wire size_8k_up = (size_r == SIZE_8K) || (size_r == SIZE_BIG);

  // Sector of the program address: top 4K is sector 0, next 4K sector 1
  wire [1:0] prog_sec =
    (paddr_r[15:12] == `SECTOR0_TOP_NIBBLE) ? 2'd0 :
    (paddr_r[15:12] == `SECTOR1_TOP_NIBBLE) ? 2'd1 : 2'd2;
  wire [1:0] erase_sec = wdata_r[`FCS_SEC_LSB +: 2];  // Taken with its start write

  // Sector present for this array size
  function automatic logic sec_avail(input logic [1:0] s, input size_code_t z);
    sec_avail = (s == 2'd0) ||
                ((s == 2'd1) && (z != SIZE_4K)) ||
                ((s == 2'd2) && (z == SIZE_BIG));
  endfunction

  // Sector 0 stays locked unless an external party drives the session
  wire prog_ok  = sec_avail(prog_sec, size_r) &&
                  (ext_mode || (prog_sec != 2'd0));
  wire erase_ok = sec_avail(erase_sec, size_r) &&
                  (ext_mode || (erase_sec != 2'd0));
  wire mass_ok  = ext_mode;
  wire opt_ok   = ext_mode;

  //////////////////////////////
  // Register write decode
  wire        wr_go   = aw_got_r && w_got_r && !bvalid_r;
  wire        wr_fcs  = wr_go && (waddr_r == A_FCS)     && wstrb_r[0];
  wire        wr_pa   = wr_go && (waddr_r == A_PADDR);
  wire        wr_pd   = wr_go && (waddr_r == A_PDATA)   && wstrb_r[0];
  wire        wr_opt  = wr_go && (waddr_r == A_OPTSTAT) && wstrb_r[0];
  wire        wr_hit  = (waddr_r == A_FCS) || (waddr_r == A_PADDR) ||
                        (waddr_r == A_PDATA) || (waddr_r == A_OPTSTAT) ||
                        (waddr_r == A_MAILBOX);
  wire        idle    = (state_r == SEQ_IDLE);
  wire [3:0]  start   = wr_fcs ? wdata_r[3:0] : 4'h0;
  wire        go_prog = idle && start[`FCS_PROG_BIT];
  wire        go_ser  = idle && start[`FCS_SERASE_BIT];
  wire        go_mer  = idle && start[`FCS_MERASE_BIT];
  wire        go_opt  = idle && start[`FCS_OPTWR_BIT];
  // A start that is refused, or arrives while busy, starts nothing and sets the refused bit
  wire        refuse  = (start != 4'h0) && (!idle ||
                        (go_prog && !prog_ok) || (go_ser && !erase_ok) ||
                        (go_mer && !mass_ok) || (go_opt && !opt_ok));

  //////////////////////////////
  // Read decode
  wire ar_take = ARVALID && arready_r;
  wire [31:0] rd_optstat = {24'h00_0000, 1'b0, mbox_full_r, 6'(size_r) << 4 |
                            6'({tool_s2_r, icc_s2_r}) << 2 |
                            6'({rp_r, opt_new_r})};
  wire [31:0] rd_val =
    (ARADDR == A_FCS)     ? {24'h00_0000, fcs_r}   :
    (ARADDR == A_PADDR)   ? {16'h0000, paddr_r}    :
    (ARADDR == A_PDATA)   ? {24'h00_0000, pdata_r} :
    (ARADDR == A_OPTSTAT) ? rd_optstat             :
    (ARADDR == A_MAILBOX) ? {24'h00_0000, mbox_r}  : 32'h0000_0000;
  wire rd_hit = (ARADDR == A_FCS) || (ARADDR == A_PADDR) ||
                (ARADDR == A_PDATA) || (ARADDR == A_OPTSTAT) ||
                (ARADDR == A_MAILBOX);

  //////////////////////////////
  // Sequencer next state
  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    req_nxt   = req_r;
    unique case (state_r)
      SEQ_IDLE:
      begin
        req_nxt = '0;
        // One operation only: program, sector erase, mass erase, option
        if (go_prog && prog_ok && !refuse)
        begin
          req_nxt = '{prog: 1'b1, erase: 1'b0, mass: 1'b0, sector: prog_sec,
                      addr: paddr_r, wdata: pdata_r};
          cnt_nxt   = PROG_CNT;
          state_nxt = SEQ_RUN;
        end
        else if (go_ser && erase_ok && !refuse)
        begin
          // Erase is raised with only the chosen sector's two-bit code on the macro
          req_nxt = '{prog: 1'b0, erase: 1'b1, mass: 1'b0, sector: erase_sec,
                      addr: 16'h0000, wdata: 8'h00};
          cnt_nxt   = ERASE_CNT;
          state_nxt = SEQ_RUN;
        end
        else if (go_mer && mass_ok && !refuse)
        begin
          req_nxt = '{prog: 1'b0, erase: 1'b1, mass: 1'b1, sector: 2'd0,
                      addr: 16'h0000, wdata: 8'h00};
          cnt_nxt   = ERASE_CNT;
          state_nxt = SEQ_RUN;
        end
        else if (go_opt && opt_ok && !refuse)
        begin
          if (rp_r && !opt_new_r)
          begin
            // Dropping protection wipes the array before the option flips
            req_nxt = '{prog: 1'b0, erase: 1'b1, mass: 1'b1, sector: 2'd0,
                        addr: 16'h0000, wdata: 8'h00};
            cnt_nxt   = ERASE_CNT;
            state_nxt = SEQ_CLEAR;
          end
          else
          begin
            cnt_nxt   = PROG_CNT;
            state_nxt = SEQ_OPT;
          end
        end
      end
      SEQ_RUN, SEQ_CLEAR:
      begin
        if (cnt_r <= 24'h00_0001)
        begin
          req_nxt   = '0;
          cnt_nxt   = PROG_CNT;
          state_nxt = (state_r == SEQ_CLEAR) ? SEQ_OPT : SEQ_IDLE;
        end
        else
        begin
          cnt_nxt = cnt_r - 24'h00_0001;
        end
      end
      SEQ_OPT:
      begin
        // Option byte write time
        if (cnt_r <= 24'h00_0001)
        begin
          state_nxt = SEQ_IDLE;
        end
        else
        begin
          cnt_nxt = cnt_r - 24'h00_0001;
        end
      end
    endcase
  end

  //////////////////////////////
  // Sequencer registers
  always_ff @(posedge CORE_CLK)
  begin
    if (!RSTN)
    begin
      state_r <= SEQ_IDLE;
      cnt_r   <= 24'h00_0000;
      req_r   <= '0;
    end
    else
    begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      req_r   <= req_nxt;
    end
  end

  //////////////////////////////
  // Straps are taken one cycle after reset release, through the syncs
  always_ff @(posedge CORE_CLK)
  begin
    if (!RSTN)
    begin
      strap_done_r <= 1'b0;
      size_r       <= SIZE_4K;
      rp_r         <= 1'b1;      // Protected until the option is known
    end
    else if (!strap_done_r)
    begin
      strap_done_r <= 1'b1;
      size_r       <= (size_s2_r == 2'b11) ? SIZE_BIG : size_code_t'(size_s2_r);
      rp_r         <= rpo_s2_r;
    end
    else if ((state_r == SEQ_OPT) && (state_nxt == SEQ_IDLE))
    begin
      rp_r <= opt_new_r;
    end
  end

  //////////////////////////////
  // Software registers
  always_ff @(posedge CORE_CLK)
  begin
    if (!RSTN)
    begin
      fcs_r     <= `FCS_RESET;
      paddr_r   <= `PADDR_RESET;
      pdata_r   <= `PDATA_RESET;
      opt_new_r <= 1'b0;
    end
    else
    begin
      // Busy mirrors the sequencer; refused is sticky and set wins
      fcs_r[`FCS_BUSY_BIT]    <= (state_nxt != SEQ_IDLE);
      fcs_r[`FCS_REFUSED_BIT] <= refuse ? 1'b1 :
                                 (wr_fcs ? wdata_r[`FCS_REFUSED_BIT] &
                                           fcs_r[`FCS_REFUSED_BIT] : fcs_r[7]);
      fcs_r[3:0] <= 4'h0;
      if (wr_fcs && idle)
      begin
        fcs_r[`FCS_SEC_LSB +: 2] <= wdata_r[`FCS_SEC_LSB +: 2];
      end
      if (wr_pa && idle)
      begin
        if (wstrb_r[0]) paddr_r[7:0]  <= wdata_r[7:0];
        if (wstrb_r[1]) paddr_r[15:8] <= wdata_r[15:8];
      end
      if (wr_pd && idle)
      begin
        pdata_r <= wdata_r[7:0];
      end
      if (wr_opt && idle)
      begin
        opt_new_r <= wdata_r[`OPT_NEW_RP_BIT];
      end
    end
  end

  //////////////////////////////
  // Mailbox from the link; a byte landing with the read wins
  always_ff @(posedge CORE_CLK)
  begin
    if (!RSTN)
    begin
      mbox_r      <= 8'h00;
      mbox_full_r <= 1'b0;
    end
    else if (byte_evt)
    begin
      mbox_r      <= link_byte;
      mbox_full_r <= 1'b1;
    end
    else if (ar_take && (ARADDR == A_MAILBOX))
    begin
      mbox_full_r <= 1'b0;
    end
  end

  //////////////////////////////
  // AXI4-Lite write channels, address and data in either order
  always_ff @(posedge CORE_CLK)
  begin
    if (!RSTN)
    begin
      awready_r <= 1'b1;
      wready_r  <= 1'b1;
      aw_got_r  <= 1'b0;
      w_got_r   <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= RESP_OK;
      waddr_r   <= 8'h00;
      wdata_r   <= 32'h0000_0000;
      wstrb_r   <= 4'h0;
    end
    else
    begin
      if (AWVALID && awready_r)
      begin
        waddr_r   <= AWADDR;
        aw_got_r  <= 1'b1;
        awready_r <= 1'b0;
      end
      if (WVALID && wready_r)
      begin
        wdata_r  <= WDATA;
        wstrb_r  <= WSTRB;
        w_got_r  <= 1'b1;
        wready_r <= 1'b0;
      end
      if (wr_go)
      begin
        bvalid_r <= 1'b1;
        bresp_r  <= wr_hit ? RESP_OK : RESP_SLV;
        aw_got_r <= 1'b0;
        w_got_r  <= 1'b0;
      end
      if (bvalid_r && BREADY)
      begin
        bvalid_r  <= 1'b0;
        awready_r <= 1'b1;
        wready_r  <= 1'b1;
      end
    end
  end

  //////////////////////////////
  // AXI4-Lite read channel, one cycle to the answer
  always_ff @(posedge CORE_CLK)
  begin
    if (!RSTN)
    begin
      arready_r <= 1'b1;
      rvalid_r  <= 1'b0;
      rdata_r   <= 32'h0000_0000;
      rresp_r   <= RESP_OK;
    end
    else if (ar_take)
    begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b1;
      rdata_r   <= rd_val;
      rresp_r   <= rd_hit ? RESP_OK : RESP_SLV;
    end
    else if (rvalid_r && RREADY)
    begin
      rvalid_r  <= 1'b0;
      arready_r <= 1'b1;
    end
  end

  //////////////////////////////
  // System enables; protection also holds external read and the detector off
  always_ff @(posedge CORE_CLK)
  begin
    if (!RSTN)
    begin
      ext_rd_r <= 1'b0;
      lvd_en_r <= 1'b0;
    end
    else
    begin
      ext_rd_r <= ext_mode && !rp_r && strap_done_r;
      lvd_en_r <= lvd_s2_r && !rp_r && strap_done_r;
    end
  end

  // Outputs straight from flops
  assign AWREADY                   = awready_r;
  assign WREADY                    = wready_r;
  assign BVALID                    = bvalid_r;
  assign BRESP                     = bresp_r;
  assign ARREADY                   = arready_r;
  assign RVALID                    = rvalid_r;
  assign RDATA                     = rdata_r;
  assign RRESP                     = rresp_r;
  assign FLASH_REQ                 = req_r;
  assign OPTION_READOUT_PROTECT    = rp_r;
  assign LOW_VOLTAGE_DETECTOR_EN   = lvd_en_r;
  assign EXT_READ_ENABLE           = ext_rd_r;
  // The receive-only link never drives the data line back
  assign INCIRCUIT_SERIAL_DATA_OUT = 1'b0;
  assign INCIRCUIT_SERIAL_DATA_OE  = 1'b0;

endmodule // sector_flash_program_control

// >>> test_sector_flash_program_control.sv
// Self-checking bench for the sectored flash sequencer
`timescale 1ns/1ns
`include "flash_ctrl_map.svh"
module test_sector_flash_program_control;
  import flash_ctrl_pkg::*;
  logic        clk = 1'b0, rstn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0, tool = 1'b0, prot = 1'b0, lvd_req = 1'b1;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000, rdata, rd_v;
  logic [1:0]  bresp, rresp, resp_v;
  logic        awready, wready, bvalid, arready, rvalid, lclk, ldata, comm;
  logic        opt_prot, lvd_en, ext_rd;
  flash_req_t  req;
  int          miscompares = 0, check_count = 0;
  localparam logic [7:0] A_FCS = `FCS_INDEX << 2, A_PADDR = `PADDR_INDEX << 2;
  localparam logic [7:0] A_OPT = `OPTSTAT_INDEX << 2, A_MBOX = `MAILBOX_INDEX << 2;
  always #50 clk = ~clk; // 10 MHz core clock
  sector_flash_program_control #(.ERASE_CYCLES(20)) sector_flash_program_control_inst (
    .CORE_CLK(clk), .RSTN(rstn), .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready),
    .WDATA(wdata), .WSTRB(4'hF), .WVALID(wvalid), .WREADY(wready), .BRESP(bresp),
    .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready),
    .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready),
    .INCIRCUIT_SERIAL_CLOCK(lclk), .INCIRCUIT_SERIAL_DATA_IN(ldata),
    .INCIRCUIT_SERIAL_DATA_OUT(), .INCIRCUIT_SERIAL_DATA_OE(), .INCIRCUIT_COMM_MODE(comm),
    .TOOL_MODE(tool), .FLASH_SIZE_STRAP(2'h1), .READOUT_PROTECT_OPTION_BIT(prot),
    .LOW_VOLTAGE_DETECTOR_REQ(lvd_req), .FLASH_REQ(req), .OPTION_READOUT_PROTECT(opt_prot),
    .LOW_VOLTAGE_DETECTOR_EN(lvd_en), .EXT_READ_ENABLE(ext_rd));
  link_tool_model link_tool_model_inst (.sclk(lclk), .sdata(ldata), .comm(comm));
  //////////////////////////////
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e)
    begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  // Write: address and data offered together, each dropped once taken
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'h7};
    do
    begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end
    while (bvalid !== 1'b1);
    bready <= 1'b0;
  endtask
  task rdc(input string n, input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    {araddr, arvalid, rready} <= {a, 2'h3};
    do
    begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end
    while (rvalid !== 1'b1);
    rready <= 1'b0;
    {rd_v, resp_v} = {rdata, rresp};
    chk(n, e, rd_v);
  endtask
  task do_reset();
    rstn <= 1'b0;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
  endtask
  task end_sim();
    $display("comparisons %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  //////////////////////////////
  initial
  begin
    do_reset();
    rdc("fcs reset", A_FCS, 32'h0000_0000);
    rdc("unmapped data", 8'hFC, 32'h0000_0000);
    chk("unmapped resp", 32'h0000_0002, {30'h0, resp_v});
    $display("reset test done");
    wr(A_PADDR, 32'h0000_F000);
    wr(A_PADDR + 8'h04, 32'h0000_0055);
    wr(A_FCS, 32'h0000_0001);
    chk("sector 0 request", 32'h0000_0000, {3'h0, req});
    rdc("sector 0 refused", A_FCS, 32'h0000_0080);
    wr(A_PADDR, 32'h0000_E123);
    wr(A_FCS, 32'h0000_0001);
    chk("program request", {8'h11, 16'hE123, 8'h55}, {3'h0, req});
    wr(A_FCS, 32'h0000_0002);
    rdc("start while busy", A_FCS, 32'h0000_00C0);
    repeat (210) @(posedge clk);
    chk("request idle", 32'h0000_0000, {3'h0, req});
    wr(A_FCS, 32'h0000_0022);
    rdc("absent sector 2", A_FCS, 32'h0000_00A0);
    $display("application mode test done");
    tool <= 1'b1;
    repeat (3) @(posedge clk);
    wr(A_FCS, 32'h0000_0002);
    chk("tool erase s0", 32'h0000_0001, {31'h0, req.erase && req.sector == 2'h0});
    chk("external read", 32'h0000_0001, {31'h0, ext_rd});
    repeat (30) @(posedge clk);
    $display("tool mode test done");
    prot <= 1'b1;
    do_reset();
    repeat (3) @(posedge clk);
    chk("read blocked", 32'h0000_0000, {31'h0, ext_rd});
    chk("detector off", 32'h0000_0000, {31'h0, lvd_en});
    wr(A_OPT, 32'h0000_0000);
    wr(A_FCS, 32'h0000_0008);
    chk("mass erase first", 32'h0000_0003, {30'h0, req.mass, opt_prot});
    repeat (240) @(posedge clk);
    chk("unprotected", 32'h0000_0003, {30'h0, !opt_prot, lvd_en});
    $display("protection test done");
    link_tool_model_inst.send(8'hA5);
    repeat (8) @(posedge clk);
    rdc("mailbox", A_MBOX, 32'h0000_00A5);
    $display("link test done");
    end_sim();
  end
  // Run takes ~600 cycles
  initial
  begin
    repeat (20000) @(posedge clk);
    miscompares++;
    end_sim();
  end
endmodule // test_sector_flash_program_control
